// [bench/cfsm_assertions.sv]
`timescale 1ns/100ps
`include "cmd_fanout_defines.vh"
// ==========================================
// Status merge, host gating and slot map checks
module cfsm_assertions #(
   parameter NSLOTS = `CF_SLOTS,
   parameter NSTATCH = `CF_STAT_CH,
   parameter NBOARDS = 8
) (
   // Clock and reset
   input logic sys_clk,
   input logic rst_n,
   // Status side
   input logic [NSTATCH*`CF_STAT_W-1:0] statusIn,
   input logic [2*`CF_STAT_W-1:0] statusOut_r,
   input logic [`CF_STAT_W-1:0] mergedStatus_r,
   input logic [NBOARDS*`CF_STAT_W-1:0] boardStatus,
   input logic [`CF_STAT_W-1:0] crateStatusBus_r,
   input logic [`CF_STAT_W-1:0] localCrateStatus,
   input logic hostDisable,
   input logic hostEnable,
   input logic fwdDisabled_r,
   input logic [`CF_STAT_W-1:0] upstreamStatus_r,
   // Slot side
   input logic slotSelWr,
   input logic [`CF_SLOT_IDX_W-1:0] slotSelIdx,
   input logic slotSelLink,
   input logic [NSLOTS-1:0] slotLinkMap_r,
   input logic crossStart_r
);
   logic [1:0] liveCnt_r;
   logic [2:0] orLo, orHi, orBrd;
   // Outputs lag the pin release by two sync flops, so hold off checks
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         liveCnt_r <= 2'h0;
      end else if (liveCnt_r != 2'h3) begin
         liveCnt_r <= liveCnt_r + 2'h1;
      end
   end
   // Reference OR trees
   always @* begin
      orLo = 3'h0;
      orHi = 3'h0;
      orBrd = 3'h0;
      for (int i = 0; i < NSTATCH; i++) begin
         if (i < `CF_STAT_GROUP) orLo = orLo | statusIn[i*3+:3];
         else orHi = orHi | statusIn[i*3+:3];
      end
      for (int i = 0; i < NBOARDS; i++) orBrd = orBrd | boardStatus[i*3+:3];
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (liveCnt_r != 2'h3);
   a_merge_all_or: assert property (
      mergedStatus_r == ($past(orLo) | $past(orHi))) else $error("merged status wrong");
   a_group_lo_or: assert property (
      statusOut_r[2:0] == $past(orLo)) else $error("low status group wrong");
   a_group_hi_or: assert property (
      statusOut_r[5:3] == $past(orHi)) else $error("high status group wrong");
   a_crate_bus_or: assert property (
      crateStatusBus_r == $past(orBrd)) else $error("crate bus wrong");
   a_upstream_mix: assert property (
      upstreamStatus_r == (($past(mergedStatus_r) & ~{3{$past(fwdDisabled_r)}})
      | $past(localCrateStatus))) else $error("upstream status wrong");
   a_disable_wins: assert property (
      hostDisable |=> fwdDisabled_r) else $error("disable not taken");
   a_enable_clears: assert property (
      hostEnable && !hostDisable |=> !fwdDisabled_r) else $error("enable not taken");
   a_slot_write: assert property (
      slotSelWr && slotSelIdx < NSLOTS |=> slotLinkMap_r[$past(slotSelIdx)] == $past(slotSelLink))
      else $error("slot map write lost");
   a_slot_keep: assert property (
      !slotSelWr || slotSelIdx >= NSLOTS |=> $stable(slotLinkMap_r)) else $error("slot map moved");
   a_cross_period: assert property (
      crossStart_r |=> !crossStart_r [*6] ##1 crossStart_r) else $error("crossing period wrong");
endmodule

// [bench/command_fanout_status_merge_tb.sv]
`timescale 1ns/100ps
`include "cmd_fanout_defines.vh"
// ==========================================
// Bench for command fan-out and status merge
module command_fanout_status_merge_tb;
   logic sys_clk, rst_n, slotSelWr, slotSelLink, crossStart_r, hostDisable, hostEnable;
   logic srcClear, fwdDisabled_r, srcSeq_r, srcLocal_r, p0Ok, p19Ok;
   logic [4:0] linkAInfo1, linkAInfo2, linkBInfo1, linkBInfo2, slotSelIdx, hitBusCmd_r;
   logic [4:0] p0Info1, p0Info2, p19Info1, p19Info2;
   logic [19:0] slotLinkMap_r, slotLine1, slotLine2;
   logic [1:0] feCross_r, feSectorReset_r, feSyncGap_r, feFirstCross_r, feL1Accept_r;
   logic [7:0] chipCmd_r, hitBus_r;
   logic [55:0] discriminatedA;
   logic [11:0] lclkStart, lclkDur;
   logic [3:0] localClk_r;
   logic [23:0] boardStatus;
   logic [2:0] crateStatusBus_r, mergedStatus_r, localCrateStatus, upstreamStatus_r;
   logic [47:0] statusIn;
   logic [5:0] statusOut_r;
   int nErrors = 0;
   int numChecks = 0;
   command_fanout_status_merge uut (.sys_clk, .rst_n, .linkAInfo1, .linkAInfo2, .linkBInfo1,
      .linkBInfo2, .slotSelWr, .slotSelIdx, .slotSelLink, .slotLinkMap_r, .slotLine1,
      .slotLine2, .crossStart_r, .feCross_r, .feSectorReset_r, .feSyncGap_r, .feFirstCross_r,
      .feL1Accept_r, .chipCmd_r, .discriminatedA, .hitBus_r, .hitBusCmd_r, .lclkStart,
      .lclkDur, .localClk_r, .boardStatus, .crateStatusBus_r, .statusIn, .statusOut_r,
      .mergedStatus_r, .localCrateStatus, .hostDisable, .hostEnable, .srcClear,
      .fwdDisabled_r, .srcSeq_r, .srcLocal_r, .upstreamStatus_r);
   // Sequencer boards on a link A slot and a link B slot
   slot_seq_model seq0 (.sysClk(sys_clk), .frameMark(crossStart_r), .line1(slotLine1[0]),
      .line2(slotLine2[0]), .info1_r(p0Info1), .info2_r(p0Info2), .frameOk_r(p0Ok));
   slot_seq_model seq19 (.sysClk(sys_clk), .frameMark(crossStart_r), .line1(slotLine1[19]),
      .line2(slotLine2[19]), .info1_r(p19Info1), .info2_r(p19Info2), .frameOk_r(p19Ok));
   // Clock, 8 ns period
   initial begin
      sys_clk = 1'h0;
      forever #4 sys_clk = ~sys_clk;
   end
   task chk(input logic [55:0] seen, input logic [55:0] exp);
      numChecks++;
      if (seen !== exp) begin
         nErrors++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task endSim;
      $display("checks %0d errors %0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Bounded wait for crossing markers; a lost marker ends the run
   task waitCross(input int n);
      int k;
      repeat (n) begin
         k = 0;
         do begin
            @(negedge sys_clk);
            k++;
         end while (crossStart_r !== 1'h1 && k < 10);
         if (k >= 10) begin
            nErrors++;
            endSim();
         end
      end
   endtask
   // ==========================================
   // Status OR trees, upstream gating and source flags
   task tStatus;
      statusIn = 48'h0040_0000_0400;
      boardStatus = 24'h00_8000;
      @(negedge sys_clk);
      chk(statusOut_r, 6'h22);
      chk(mergedStatus_r, 3'h6);
      chk(crateStatusBus_r, 3'h1);
      hostDisable = 1'h1;
      localCrateStatus = 3'h1;
      @(negedge sys_clk);
      hostDisable = 1'h0;
      chk(fwdDisabled_r, 1'h1);
      chk(srcSeq_r, 1'h1);
      @(negedge sys_clk);
      chk(upstreamStatus_r, 3'h1);
      hostDisable = 1'h1;
      hostEnable = 1'h1;
      @(negedge sys_clk);
      chk(fwdDisabled_r, 1'h1);
      hostDisable = 1'h0;
      @(negedge sys_clk);
      hostEnable = 1'h0;
      chk(fwdDisabled_r, 1'h0);
      chk(srcLocal_r, 1'h1);
      statusIn = 48'h0;
      localCrateStatus = 3'h0;
      @(negedge sys_clk);
      chk(upstreamStatus_r, 3'h6);
      @(negedge sys_clk);
      srcClear = 1'h1;
      @(negedge sys_clk);
      srcClear = 1'h0;
      chk({srcSeq_r, srcLocal_r}, 2'h0);
   endtask
   // Slot remap, refused index and frames seen by the sequencers
   task tSlots;
      linkAInfo1 = 5'h15;
      linkAInfo2 = 5'h12;
      linkBInfo1 = 5'h0A;
      linkBInfo2 = 5'h0C;
      slotSelWr = 1'h1;
      slotSelIdx = 5'h13;
      slotSelLink = 1'h1;
      @(negedge sys_clk);
      slotSelIdx = 5'h14;
      @(negedge sys_clk);
      slotSelWr = 1'h0;
      chk(slotLinkMap_r, 20'h8_0000);
      waitCross(3);
      chk({p0Info1, p0Info2, p0Ok}, 11'h565);
      chk({p19Info1, p19Info2, p19Ok}, 11'h299);
      chk(chipCmd_r, 8'h5A);
      chk({feCross_r, feSectorReset_r}, 4'h5);
      chk({feSyncGap_r, feFirstCross_r, feL1Accept_r}, 6'h29);
      chk(hitBusCmd_r, 5'h12);
   endtask
   // Hit slices per phase and local clock windows
   task tHits;
      discriminatedA = 56'h66_5544_3322_1100;
      lclkStart = 12'hC22;
      lclkDur = 12'h1D3;
      waitCross(1);
      for (int k = 0; k < 7; k++) begin
         chk(hitBus_r, 8'h11 * k);
         chk(localClk_r, {2'h1, k >= 4 && k < 6, k >= 2 && k < 5});
         @(negedge sys_clk);
      end
   endtask
   // ==========================================
   // Main sequence, including a reset in mid-run
   initial begin
      rst_n = 1'h0;
      {linkAInfo1, linkAInfo2, linkBInfo1, linkBInfo2, slotSelWr, slotSelIdx, slotSelLink,
         discriminatedA, lclkStart, lclkDur, boardStatus, statusIn, localCrateStatus,
         hostDisable, hostEnable, srcClear} = '0;
      repeat (4) @(negedge sys_clk);
      rst_n = 1'h1;
      repeat (4) @(negedge sys_clk);
      tStatus();
      tSlots();
      rst_n = 1'h0;
      @(negedge sys_clk);
      chk({slotLinkMap_r, fwdDisabled_r}, 21'h0);
      rst_n = 1'h1;
      repeat (4) @(negedge sys_clk);
      tHits();
      endSim();
   end
endmodule

bind command_fanout_status_merge cfsm_assertions #(.NSLOTS(NSLOTS), .NSTATCH(NSTATCH),
   .NBOARDS(NBOARDS)) chkU (.sys_clk, .rst_n, .statusIn, .statusOut_r, .mergedStatus_r,
   .boardStatus, .crateStatusBus_r, .localCrateStatus, .hostDisable, .hostEnable,
   .fwdDisabled_r, .upstreamStatus_r, .slotSelWr, .slotSelIdx, .slotSelLink,
   .slotLinkMap_r, .crossStart_r);

// [bench/slot_seq_model.sv]
`timescale 1ns/100ps
// ==========================================
// Sequencer slot receiver: decodes both NRZ lines of one slot
module slot_seq_model (
   // Clock and frame marker
   input logic sysClk,
   input logic frameMark,
   // Backplane lines
   input logic line1,
   input logic line2,
   // Decoded frame
   output logic [4:0] info1_r,
   output logic [4:0] info2_r,
   output logic frameOk_r = 1'h0
);
   logic [6:0] sh1_r, sh2_r;
   logic seen_r = 1'h0;
   // Latch the previous frame at each marker; bad framing or parity flags it
   always @(posedge sysClk) begin
      if (frameMark && seen_r) begin
         info1_r <= sh1_r[5:1];
         info2_r <= sh2_r[5:1];
         frameOk_r <= sh1_r[6] & sh2_r[6] & ~^sh1_r & ~^sh2_r;
      end
      if (frameMark) seen_r <= 1'h1;
      sh1_r <= {sh1_r[5:0], line1};
      sh2_r <= {sh2_r[5:0], line2};
   end
endmodule

// [hdl/command_fanout_status_merge.v]
// What this block does
// - Two independent command links, one sector each
// - Fan link frames to 20 programmable slots
// - Decode frames into front-end control signals
// - Forward command info with hit data
// - Board status placed on crate-wide bus
// - Merge all crate status by logical OR
// - Record status source for host readback
// - Send combined status back upstream
// - Host disable blocks sequencer status forwarding
// - Each local clock has own start, duration
// - Discriminated_a multiplexed seven cycles per crossing
// - Each slot independently picks either link
// - 16x3 status in, groups of eight ORed
`timescale 1ns/100ps
`include "cmd_fanout_defines.vh"

module command_fanout_status_merge #(
   parameter NSLOTS = `CF_SLOTS,
   parameter NSTATCH = `CF_STAT_CH,
   parameter NBOARDS = 8,
   parameter HITW = 8,
   parameter NLCLK = 4
) (
   // Clock and reset
   input wire sys_clk,
   input wire rst_n,
   // Command links, sampled at crossing start
   input wire [`CF_INFO_W-1:0] linkAInfo1,
   input wire [`CF_INFO_W-1:0] linkAInfo2,
   input wire [`CF_INFO_W-1:0] linkBInfo1,
   input wire [`CF_INFO_W-1:0] linkBInfo2,
   // Remote slot selection
   input wire slotSelWr,
   input wire [`CF_SLOT_IDX_W-1:0] slotSelIdx,
   input wire slotSelLink,
   output reg [NSLOTS-1:0] slotLinkMap_r,
   // Backplane slot lines
   output wire [NSLOTS-1:0] slotLine1,
   output wire [NSLOTS-1:0] slotLine2,
   output reg crossStart_r,
   // Decoded control, one set per link
   output reg [1:0] feCross_r,
   output reg [1:0] feSectorReset_r,
   output reg [1:0] feSyncGap_r,
   output reg [1:0] feFirstCross_r,
   output reg [1:0] feL1Accept_r,
   output reg [7:0] chipCmd_r,
   // Hit path to the digital track board
   input wire [`CF_PHASES*HITW-1:0] discriminatedA,
   output reg [HITW-1:0] hitBus_r,
   output reg [`CF_INFO_W-1:0] hitBusCmd_r,
   // Local clocks
   input wire [NLCLK*`CF_PHASE_W-1:0] lclkStart,
   input wire [NLCLK*`CF_PHASE_W-1:0] lclkDur,
   output reg [NLCLK-1:0] localClk_r,
   // Status return
   input wire [NBOARDS*`CF_STAT_W-1:0] boardStatus,
   output reg [`CF_STAT_W-1:0] crateStatusBus_r,
   input wire [NSTATCH*`CF_STAT_W-1:0] statusIn,
   output reg [2*`CF_STAT_W-1:0] statusOut_r,
   output reg [`CF_STAT_W-1:0] mergedStatus_r,
   // Readout crate controller
   input wire [`CF_STAT_W-1:0] localCrateStatus,
   input wire hostDisable,
   input wire hostEnable,
   input wire srcClear,
   output reg fwdDisabled_r,
   output reg srcSeq_r,
   output reg srcLocal_r,
   output reg [`CF_STAT_W-1:0] upstreamStatus_r
);

   // ==========================================================
   // Reset release through two flops
   reg rstMeta_r;
   reg rstSync_r;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_r <= 1'h0;
         rstSync_r <= 1'h0;
      end else begin
         rstMeta_r <= 1'h1;
         rstSync_r <= rstMeta_r;
      end
   end

   // ==========================================================
   // Crossing phase counter, seven clocks per crossing
   reg [`CF_PHASE_W-1:0] phase_r;
   wire frameLoad;

   assign frameLoad = (phase_r == `CF_PHASE_FIRST);

   always @(posedge sys_clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         phase_r <= `CF_PHASE_FIRST;
         crossStart_r <= 1'h0;
      end else begin
         phase_r <= (phase_r == `CF_PHASE_LAST) ? `CF_PHASE_FIRST
                    : phase_r + `CF_PHASE_ONE;
         crossStart_r <= frameLoad;
      end
   end

   // ==========================================================
   // Slot selection map, set and sensed remotely
   always @(posedge sys_clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         slotLinkMap_r <= {NSLOTS{`CF_LINK_A}};
      end else if (slotSelWr && (slotSelIdx < NSLOTS)) begin
         slotLinkMap_r[slotSelIdx] <= slotSelLink;
      end
   end

   // ==========================================================
   // Per-slot fan-out; each slot reads its own map bit
   genvar s;
   generate
      for (s = 0; s < NSLOTS; s = s + 1) begin : gSlot
         wire [`CF_INFO_W-1:0] selInfo1;
         wire [`CF_INFO_W-1:0] selInfo2;
         // Link mux per slot, no slot depends on another
         assign selInfo1 = slotLinkMap_r[s] ? linkBInfo1 : linkAInfo1;
         assign selInfo2 = slotLinkMap_r[s] ? linkBInfo2 : linkAInfo2;
         nrz_slot_tx uTx (
            .sysClk(sys_clk),
            .rstSync_n(rstSync_r),
            .frameLoad(frameLoad),
            .info1(selInfo1),
            .info2(selInfo2),
            .line1Out_r(slotLine1[s]),
            .line2Out_r(slotLine2[s])
         );
      end
   endgenerate

   // ==========================================================
   // Decode each link into front-end control, held per crossing
   always @(posedge sys_clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         feCross_r <= 2'h0;
         feSectorReset_r <= 2'h0;
         feSyncGap_r <= 2'h0;
         feFirstCross_r <= 2'h0;
         feL1Accept_r <= 2'h0;
         chipCmd_r <= 8'h00;
      end else if (frameLoad) begin
         feCross_r <= {linkBInfo1[`CF_L1_CROSS], linkAInfo1[`CF_L1_CROSS]};
         feSectorReset_r <= {linkBInfo2[`CF_L2_RESET], linkAInfo2[`CF_L2_RESET]};
         feSyncGap_r <= {linkBInfo2[`CF_L2_SYNCGAP], linkAInfo2[`CF_L2_SYNCGAP]};
         feFirstCross_r <= {linkBInfo2[`CF_L2_FIRST], linkAInfo2[`CF_L2_FIRST]};
         feL1Accept_r <= {linkBInfo2[`CF_L2_L1ACC], linkAInfo2[`CF_L2_L1ACC]};
         chipCmd_r <= {linkBInfo1[`CF_L1_CMD_HI:`CF_L1_CMD_LO],
                      linkAInfo1[`CF_L1_CMD_HI:`CF_L1_CMD_LO]};
      end
   end

   // ==========================================================
   // Hit multiplexing; link A info rides along on the same word
   always @(posedge sys_clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         hitBus_r <= {HITW{1'h0}};
         hitBusCmd_r <= 5'h00;
      end else begin
         hitBus_r <= discriminatedA[phase_r*HITW +: HITW];
         if (frameLoad) begin
            hitBusCmd_r <= linkAInfo2;
         end
      end
   end

   // ==========================================================
   // Local clocks: window within the crossing, each its own
   // start and length; wraps are not supported, keep start+dur <= 7
   wire [NLCLK-1:0] lclkOn;
   genvar c;
   generate
      for (c = 0; c < NLCLK; c = c + 1) begin : gLclk
         wire [`CF_PHASE_W:0] st;
         wire [`CF_PHASE_W:0] en;
         assign st = {1'h0, lclkStart[c*`CF_PHASE_W +: `CF_PHASE_W]};
         assign en = st + {1'h0, lclkDur[c*`CF_PHASE_W +: `CF_PHASE_W]};
         assign lclkOn[c] = ({1'h0, phase_r} >= st) && ({1'h0, phase_r} < en);
      end
   endgenerate

   // One register for all windows, so the vector has a single driver
   always @(posedge sys_clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         localClk_r <= {NLCLK{1'h0}};
      end else begin
         localClk_r <= lclkOn;
      end
   end

   // ==========================================================
   // Status OR trees, bit by bit
   reg [`CF_STAT_W-1:0] crateOr;
   reg [`CF_STAT_W-1:0] grpLo;
   reg [`CF_STAT_W-1:0] grpHi;
   integer i;

   always @* begin
      crateOr = `CF_STAT_ZERO;
      grpLo = `CF_STAT_ZERO;
      grpHi = `CF_STAT_ZERO;
      for (i = 0; i < NBOARDS; i = i + 1) begin
         crateOr = crateOr | boardStatus[i*`CF_STAT_W +: `CF_STAT_W];
      end
      for (i = 0; i < NSTATCH; i = i + 1) begin
         if (i < `CF_STAT_GROUP) begin
            grpLo = grpLo | statusIn[i*`CF_STAT_W +: `CF_STAT_W];
         end else begin
            grpHi = grpHi | statusIn[i*`CF_STAT_W +: `CF_STAT_W];
         end
      end
   end

   always @(posedge sys_clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         crateStatusBus_r <= `CF_STAT_ZERO;
         statusOut_r <= 6'h00;
         mergedStatus_r <= `CF_STAT_ZERO;
      end else begin
         crateStatusBus_r <= crateOr;
         statusOut_r <= {grpHi, grpLo};
         mergedStatus_r <= grpHi | grpLo;
      end
   end

   // ==========================================================
   // Readout crate controller: source record, gate, upstream
   wire [`CF_STAT_W-1:0] seqGated;
   wire seqSeen;
   wire localSeen;

   assign seqGated = fwdDisabled_r ? `CF_STAT_ZERO : mergedStatus_r;
   assign seqSeen = |seqGated;
   assign localSeen = |localCrateStatus;

   // Source flags are sticky; a new event wins over a clear
   always @(posedge sys_clk or negedge rstSync_r) begin
      if (!rstSync_r) begin
         srcSeq_r <= 1'h0;
         srcLocal_r <= 1'h0;
         fwdDisabled_r <= 1'h0;
         upstreamStatus_r <= `CF_STAT_ZERO;
      end else begin
         srcSeq_r <= seqSeen | (srcSeq_r & ~srcClear);
         srcLocal_r <= localSeen | (srcLocal_r & ~srcClear);
         if (hostDisable) begin
            fwdDisabled_r <= 1'h1;
         end else if (hostEnable) begin
            fwdDisabled_r <= 1'h0;
         end
         upstreamStatus_r <= seqGated | localCrateStatus;
      end
   end

endmodule

// [hdl/nrz_slot_tx.v]
`timescale 1ns/100ps
`include "cmd_fanout_defines.vh"

// One backplane slot: two 7-bit NRZ frames, framing bit first
module nrz_slot_tx (
   // Clock and reset
   input wire sysClk,
   input wire rstSync_n,
   // Frame load
   input wire frameLoad,
   input wire [`CF_INFO_W-1:0] info1,
   input wire [`CF_INFO_W-1:0] info2,
   // Backplane lines
   output reg line1Out_r,
   output reg line2Out_r
);

   reg [`CF_FRAME_W-2:0] shift1_r;
   reg [`CF_FRAME_W-2:0] shift2_r;
   wire par1;
   wire par2;

   // ==========================================================
   // Parity over framing bit and five info bits
   assign par1 = ^{`CF_FRAME_BIT, info1};
   assign par2 = ^{`CF_FRAME_BIT, info2};

   // Framing bit goes out on the load edge, rest shifts behind it;
   // NRZ so a run of ones simply holds the line high
   always @(posedge sysClk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         line1Out_r <= 1'h0;
         line2Out_r <= 1'h0;
         shift1_r <= 6'h00;
         shift2_r <= 6'h00;
      end else if (frameLoad) begin
         line1Out_r <= `CF_FRAME_BIT;
         line2Out_r <= `CF_FRAME_BIT;
         shift1_r <= {info1, par1};
         shift2_r <= {info2, par2};
      end else begin
         line1Out_r <= shift1_r[`CF_FRAME_W-2];
         line2Out_r <= shift2_r[`CF_FRAME_W-2];
         shift1_r <= {shift1_r[`CF_FRAME_W-3:0], 1'h0};
         shift2_r <= {shift2_r[`CF_FRAME_W-3:0], 1'h0};
      end
   end

endmodule

// [include/cmd_fanout_defines.vh]
`ifndef CMD_FANOUT_DEFINES_VH
`define CMD_FANOUT_DEFINES_VH

// ==========================================================
// Crossing timing
// Cycles of sys_clk per crossing frame
`define CF_PHASES 7
`define CF_PHASE_W 3
`define CF_PHASE_FIRST 3'h0
`define CF_PHASE_LAST 3'h6
`define CF_PHASE_ONE 3'h1

// ==========================================================
// Frame layout (7 bits, framing bit first)
`define CF_FRAME_W 7
`define CF_INFO_W 5
`define CF_FRAME_BIT 1'h1

// Info bit positions, line 1 (info bit 4 is frame bit 2)
`define CF_L1_CROSS 0
`define CF_L1_CMD_LO 1
`define CF_L1_CMD_HI 4

// Info bit positions, line 2
`define CF_L2_SPARE 0
`define CF_L2_RESET 1
`define CF_L2_SYNCGAP 2
`define CF_L2_FIRST 3
`define CF_L2_L1ACC 4

// ==========================================================
// Status return
`define CF_STAT_W 3
`define CF_STAT_CH 16
`define CF_STAT_GROUP 8
`define CF_STAT_ZERO 3'h0

// ==========================================================
// Slot fan-out
`define CF_SLOTS 20
`define CF_SLOT_IDX_W 5
`define CF_LINK_A 1'h0
`define CF_LINK_B 1'h1

`endif
